// >>> hw/plcg_clock_gen.sv
// PLL control, controller clock path, USB clock gate and line clocks
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`default_nettype none
module plcg_clock_gen #(
  parameter int unsigned LOCK_CYCLES = plcg_pkg::LOCK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Line side inputs
  input  wire logic        rx_line,
  input  wire logic        subscriber_awake_n,
  input  wire logic        cv_pair_valid,
  input  wire logic        cv_pair_lost,
  input  wire logic        watchdog_expired,
  // PLL and clock path controls
  output logic             pll_enable,
  output logic [4:0]       pll_mult,
  output logic [3:0]       pll_div,
  output logic [1:0]       mcu_clk_mode,
  output logic             mcu_clk_run,
  output logic             usb_clk_run,
  // Serial interface clocks
  output logic             interface_data_clock,
  output logic             interface_bit_clock,
  output logic             frame_sync,
  output logic             tx_frame_start,
  output logic             rx_bit,
  output logic             rx_bit_valid,
  output logic             line_reset_pulse
);
  localparam int unsigned LW = $clog2(LOCK_CYCLES + 1);
  localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_CYCLES - 1);

  typedef struct packed {
    logic [4:0]         n;
    logic [3:0]         m;
    logic               psc_en;
    logic               psc_val;
    logic               pll_en;
    logic               sel;
    logic               usb_en;
    logic [3:0]         cmd;
    logic               lock;
    logic [LW-1:0]      lock_cnt;
    plcg_pkg::plcg_ck_e ck_state;
    logic [1:0]         mode;
    logic [3:0]         gap_cnt;
    logic               mcu_run;
    logic               usb_run;
    logic               wait_n;
    logic [31:0]        rdata;
    logic               aw_s1;
    logic               aw_s2;
    logic               aw_prev;
    logic               bck;
    logic [7:0]         frame_cnt;
    logic               fsy;
    logic               tx_start;
    logic               synced;
    logic [1:0]         pair_cnt;
    logic [1:0]         rst_frames;
    logic               rst_out;
  } plcg_top_s;

  plcg_top_s   q_r;
  plcg_top_s   q_nxt;
  plcg_line_if lk ();

  plcg_rx_tracker u_tracker (
    .clk     (clk),
    .reset_n (reset_n),
    .rx_line (rx_line),
    .lk      (lk.tracker)
  );

  logic       req;
  logic       take;
  logic       wr;
  logic [1:0] mode_req;
  logic       rst_trig;
  logic       frame_wrap;

  always_comb begin
    q_nxt      = q_r;
    req        = avs_read | avs_write;
    take       = req & ~q_r.wait_n;
    wr         = take & avs_write;
    rst_trig   = 1'b0;
    frame_wrap = 1'b0;
    mode_req   = plcg_pkg::PLCG_M_XTAL;

    // Bus: waitrequest drops for exactly one cycle per request
    q_nxt.wait_n = !(req && q_r.wait_n);
    if (req && q_r.wait_n && avs_read) begin
      case (avs_address)
        plcg_pkg::IDX_FACTOR_A: q_nxt.rdata = {27'h0000000, q_r.n};
        plcg_pkg::IDX_FACTOR_B: q_nxt.rdata = {24'h000000, q_r.sel, q_r.pll_en, q_r.psc_val,
                                               q_r.psc_en, q_r.m};
        plcg_pkg::IDX_USB_CTRL: q_nxt.rdata = {31'h00000000, q_r.usb_en};
        plcg_pkg::IDX_STATUS:   q_nxt.rdata = {28'h0000000, q_r.rst_out,
                                               q_r.ck_state == plcg_pkg::PLCG_CK_HOLD,
                                               q_r.synced, q_r.lock}; // RL5
        plcg_pkg::IDX_LINE:     q_nxt.rdata = {28'h0000000, q_r.cmd};
        default:                q_nxt.rdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (avs_address)
        plcg_pkg::IDX_FACTOR_A: q_nxt.n = avs_writedata[4:0]; // RL1
        plcg_pkg::IDX_FACTOR_B: begin
          q_nxt.m       = avs_writedata[3:0]; // RL1
          q_nxt.psc_en  = avs_writedata[plcg_pkg::B_PSC_EN];
          q_nxt.psc_val = avs_writedata[plcg_pkg::B_PSC_VAL];
          q_nxt.pll_en  = avs_writedata[plcg_pkg::B_PLL_EN];
          q_nxt.sel     = avs_writedata[plcg_pkg::B_SEL];
        end
        plcg_pkg::IDX_USB_CTRL: q_nxt.usb_en = avs_writedata[0]; // RL8
        plcg_pkg::IDX_LINE: begin
          q_nxt.cmd = avs_writedata[3:0];
          if (avs_writedata[3:0] != q_r.cmd) begin
            rst_trig = 1'b1; // RL18
          end
          if (avs_writedata[plcg_pkg::B_SWRES]) begin
            rst_trig = 1'b1;
          end
        end
        default: q_nxt.n = q_r.n;
      endcase
    end

    // PLL lock timer restarts on any factor or enable change
    if (!q_r.pll_en || (wr && (avs_address == plcg_pkg::IDX_FACTOR_A
                               || avs_address == plcg_pkg::IDX_FACTOR_B))) begin
      q_nxt.lock     = 1'b0; // RL4
      q_nxt.lock_cnt = '0;
    end else if (q_r.lock_cnt == LOCK_LAST) begin
      q_nxt.lock = 1'b1; // RL5
    end else begin
      q_nxt.lock_cnt = q_r.lock_cnt + LW'(1);
    end

    // Controller clock source; an idle PLL is never requested as the source
    if (q_r.sel && q_r.pll_en) begin
      if (!q_r.psc_en) begin
        mode_req = plcg_pkg::PLCG_M_PLL; // RL6
      end else if (q_r.psc_val) begin
        mode_req = plcg_pkg::PLCG_M_DIV1P5; // RL7
      end else begin
        mode_req = plcg_pkg::PLCG_M_DIV2; // RL7
      end
    end else begin
      mode_req = plcg_pkg::PLCG_M_XTAL; // RL3
    end

    // Gate both clocks quiet for a gap around a source change
    case (q_r.ck_state)
      plcg_pkg::PLCG_CK_RUN: begin
        q_nxt.usb_run = q_r.usb_en; // RL8
        if (mode_req != q_r.mode) begin
          q_nxt.ck_state = plcg_pkg::PLCG_CK_HOLD; // RL19
          q_nxt.mcu_run  = 1'b0;
          q_nxt.usb_run  = 1'b0;
          q_nxt.gap_cnt  = '0;
        end
      end
      plcg_pkg::PLCG_CK_HOLD: begin
        q_nxt.gap_cnt = q_r.gap_cnt + 4'h1;
        if (q_r.gap_cnt == plcg_pkg::SWITCH_GAP) begin
          q_nxt.mode     = mode_req; // RL19
          q_nxt.mcu_run  = 1'b1;
          q_nxt.ck_state = plcg_pkg::PLCG_CK_RUN;
        end
      end
      default: q_nxt.ck_state = plcg_pkg::PLCG_CK_RUN;
    endcase

    // Awake pin: two flops before the edge detector
    q_nxt.aw_s1   = subscriber_awake_n;
    q_nxt.aw_s2   = q_r.aw_s1;
    q_nxt.aw_prev = q_r.aw_s2;
    if (q_r.aw_prev && !q_r.aw_s2) begin
      rst_trig = 1'b1;
    end
    if (watchdog_expired) begin
      rst_trig = 1'b1;
    end

    // Line frame: bit clock and frame counter step on recovered data clock rises; the sync snap does not wait for one
    q_nxt.tx_start = 1'b0;
    if (lk.dck_rise) begin
      q_nxt.bck = ~q_r.bck; // RL15
      if (q_r.frame_cnt == plcg_pkg::FRAME_LAST) begin
        q_nxt.frame_cnt = 8'h00; // RL10
        frame_wrap      = 1'b1;
      end else begin
        q_nxt.frame_cnt = q_r.frame_cnt + 8'h01;
      end
    end
    if (cv_pair_lost) begin
      q_nxt.synced   = 1'b0;
      q_nxt.pair_cnt = 2'h0;
    end else if (cv_pair_valid && !q_r.synced) begin
      q_nxt.pair_cnt = q_r.pair_cnt + 2'h1;
      if (q_r.pair_cnt + 2'h1 == plcg_pkg::SYNC_PAIRS) begin
        q_nxt.synced    = 1'b1;
        q_nxt.frame_cnt = 8'h00; // RL17
        frame_wrap      = 1'b1;
      end
    end
    q_nxt.fsy = (q_nxt.frame_cnt < plcg_pkg::FSY_HIGH); // RL9
    if (lk.dck_rise && q_nxt.frame_cnt == plcg_pkg::TX_OFFSET) begin
      q_nxt.tx_start = 1'b1; // RL13
    end

    // Reset pulse ends on the second frame start, so 125 to 250 us
    if (rst_trig) begin
      q_nxt.rst_out    = 1'b1; // RL18
      q_nxt.rst_frames = 2'h0;
    end else if (q_r.rst_out && frame_wrap) begin
      q_nxt.rst_frames = q_r.rst_frames + 2'h1; // RL11
      if (q_r.rst_frames + 2'h1 == plcg_pkg::RST_FRAMES) begin
        q_nxt.rst_out = 1'b0; // RL11
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_r          <= '0;
      q_r.n        <= plcg_pkg::N_RESET; // RL2
      q_r.m        <= plcg_pkg::M_RESET; // RL2
      q_r.mode     <= plcg_pkg::PLCG_M_XTAL; // RL3
      q_r.ck_state <= plcg_pkg::PLCG_CK_RUN;
      q_r.mcu_run  <= 1'b1;
      q_r.wait_n   <= 1'b1;
      q_r.aw_s1    <= 1'b1;
      q_r.aw_s2    <= 1'b1;
      q_r.aw_prev  <= 1'b1;
      q_r.fsy      <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign avs_readdata         = q_r.rdata;
  assign avs_waitrequest      = q_r.wait_n;
  assign pll_enable           = q_r.pll_en; // RL4
  assign pll_mult             = q_r.n;
  assign pll_div              = q_r.m;
  assign mcu_clk_mode         = q_r.mode;
  assign mcu_clk_run          = q_r.mcu_run;
  assign usb_clk_run          = q_r.usb_run;
  assign interface_data_clock = lk.dck;
  assign interface_bit_clock  = q_r.bck;
  assign frame_sync           = q_r.fsy;
  assign tx_frame_start       = q_r.tx_start;
  assign rx_bit               = lk.rx_bit;
  assign rx_bit_valid         = lk.rx_valid;
  assign line_reset_pulse     = q_r.rst_out;
endmodule
`default_nettype wire

// >>> hw/plcg_rx_tracker.sv
// Receive phase tracker: recovered data clock and majority bit decision
`default_nettype none
module plcg_rx_tracker (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset_n,
  // Line pin
  input  wire logic   rx_line,
  // To core
  plcg_line_if.tracker lk
);
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       s3;
    logic [5:0] pc;
    logic [5:0] len;
    logic       dck;
    logic       dck_rise;
    logic [2:0] bitpos;
    logic       va;
    logic       vb;
    logic       rx_bit;
    logic       rx_valid;
  } plcg_trk_s;

  plcg_trk_s q_r;
  plcg_trk_s q_nxt;

  always_comb begin
    q_nxt          = q_r;
    q_nxt.s1       = rx_line;
    q_nxt.s2       = q_r.s1;
    q_nxt.s3       = q_r.s2;
    q_nxt.dck_rise = 1'b0;
    q_nxt.rx_valid = 1'b0;
    if (q_r.pc >= q_r.len - 6'h01) begin
      q_nxt.pc       = 6'h00;
      q_nxt.len      = plcg_pkg::DCK_LEN;
      q_nxt.dck_rise = 1'b1;
      q_nxt.bitpos   = q_r.bitpos + 3'h1;
    end else begin
      q_nxt.pc = q_r.pc + 6'h01;
    end
    // Late edge stretches, early edge shrinks the running cycle
    if (q_r.s3 && !q_r.s2 && q_r.pc != 6'h00) begin
      if (q_r.pc < plcg_pkg::DCK_HALF) begin
        q_nxt.len = plcg_pkg::DCK_LEN + ((q_r.pc > plcg_pkg::ADJ_SPLIT) ? plcg_pkg::ADJ_LARGE
                                                                           : plcg_pkg::ADJ_SMALL); // RL14
      end else begin
        q_nxt.len = plcg_pkg::DCK_LEN - (((plcg_pkg::DCK_LEN - q_r.pc) > plcg_pkg::ADJ_SPLIT)
                                          ? plcg_pkg::ADJ_LARGE : plcg_pkg::ADJ_SMALL); // RL14
      end
    end
    // Level only decodes the counter, so a shortened phase is never lost
    q_nxt.dck = (q_nxt.pc < plcg_pkg::DCK_HALF); // RL16
    if (q_nxt.dck_rise) begin
      case (q_nxt.bitpos)
        plcg_pkg::SMP_A: q_nxt.va = q_r.s3;
        plcg_pkg::SMP_B: q_nxt.vb = q_r.s3;
        plcg_pkg::SMP_C: begin
          q_nxt.rx_bit   = (q_r.va & q_r.vb) | (q_r.va & q_r.s3) | (q_r.vb & q_r.s3); // RL12
          q_nxt.rx_valid = 1'b1;
        end
        default: q_nxt.va = q_r.va;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_r     <= '0;
      q_r.len <= plcg_pkg::DCK_LEN;
      // First edge wraps, so the first rise also steps the bit clock
      q_r.pc  <= plcg_pkg::DCK_LEN - 6'h01;
      q_r.s1  <= 1'b1;
      q_r.s2  <= 1'b1;
      q_r.s3  <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign lk.dck_rise = q_r.dck_rise;
  assign lk.dck      = q_r.dck;
  assign lk.rx_bit   = q_r.rx_bit;
  assign lk.rx_valid = q_r.rx_valid;
endmodule
`default_nettype wire

// >>> include/plcg_line_if.sv
// Interface from the receive phase tracker to the clock core
`default_nettype none
interface plcg_line_if;
  logic dck_rise;
  logic dck;
  logic rx_bit;
  logic rx_valid;
  modport tracker (output dck_rise, output dck, output rx_bit, output rx_valid);
  modport core    (input dck_rise, input dck, input rx_bit, input rx_valid);
endinterface
`default_nettype wire

// >>> include/plcg_pkg.sv
// Package for the PLL clock and line clock generator: constants and types
// How it works
// [RL1] PLL output equals input times (N+1)/(M+1); N 0..31, M 0..15.
// [RL2] Reset factors are N=24 and M=3, giving 48 MHz from 7.68 MHz.
// [RL3] After reset the PLL is off and the controller runs from the crystal.
// [RL4] Firmware programs factors before enabling; PLL stays inactive until enabled.
// [RL5] Once enabled, a readable locked flag sets after the lock time.
// [RL6] Clock select routes crystal or PLL; firmware selects PLL only after lock.
// [RL7] Prescaler on: PLL divided by 2 when ratio select is 0, by 1.5 when 1.
// [RL8] USB clock gated after reset; opened only by the USB clock enable bit.
// [RL9] Terminal mode: 1536 kHz data clock, 8 kHz frame sync 1:2, 768 kHz bit clock.
// [RL10] All serial interface clocks follow the recovered line timing.
// [RL11] Frame sync is the timebase for reset pulse lengths.
// [RL12] Line signal sampled several times per bit, bit decided by majority.
// [RL13] Bit clocks come from the line; transmit frame lags receive frame by two bits.
// [RL14] Track falling line edges; stretch or shrink a data clock cycle by one or two steps.
// [RL15] Every other line clock derives from the recovered data clock.
// [RL16] Logic must tolerate short recovered clock phases during resync.
// [RL17] After three valid code violation pairs, frame sync snaps to fixed phase once.
// [RL18] Command code change gives a reset pulse of 125 to 250 us, timed by frame sync.
// [RL19] Source switching and USB gating produce no truncated clock pulses.
`default_nettype none
package plcg_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned DCK_HZ       = 1_536_000;
  localparam int unsigned DCK_PER      = CLK_HZ / DCK_HZ;
  localparam logic [5:0]  DCK_LEN      = 6'(DCK_PER);
  localparam logic [5:0]  DCK_HALF     = 6'(DCK_PER / 2);
  localparam logic [5:0]  ADJ_SPLIT    = 6'(DCK_PER / 4);
  localparam logic [5:0]  ADJ_SMALL    = 6'h01;
  localparam logic [5:0]  ADJ_LARGE    = 6'h02;
  localparam logic [2:0]  SMP_A        = 3'h2;
  localparam logic [2:0]  SMP_B        = 3'h4;
  localparam logic [2:0]  SMP_C        = 3'h6;
  localparam logic [7:0]  FRAME_LAST   = 8'hBF;
  localparam logic [7:0]  FSY_HIGH     = 8'h40;
  localparam logic [7:0]  TX_OFFSET    = 8'h10;
  localparam logic [1:0]  SYNC_PAIRS   = 2'h3;
  localparam logic [1:0]  RST_FRAMES   = 2'h2;
  localparam logic [3:0]  SWITCH_GAP   = 4'h4;
  localparam int unsigned LOCK_TIME_US = 2000;
  localparam int unsigned LOCK_CYCLES  = LOCK_TIME_US * (CLK_HZ / 1_000_000);
  // Word indices of the registers, byte address is four times the index
  localparam logic [2:0]  IDX_FACTOR_A = 3'h0;
  localparam logic [2:0]  IDX_FACTOR_B = 3'h1;
  localparam logic [2:0]  IDX_USB_CTRL = 3'h2;
  localparam logic [2:0]  IDX_STATUS   = 3'h3;
  localparam logic [2:0]  IDX_LINE     = 3'h4;
  localparam logic [4:0]  N_RESET      = 5'h18;
  localparam logic [3:0]  M_RESET      = 4'h3;
  localparam int unsigned B_PSC_EN     = 4;
  localparam int unsigned B_PSC_VAL    = 5;
  localparam int unsigned B_PLL_EN     = 6;
  localparam int unsigned B_SEL        = 7;
  localparam int unsigned B_SWRES      = 4;
  typedef enum logic [1:0] {PLCG_M_XTAL, PLCG_M_PLL, PLCG_M_DIV2, PLCG_M_DIV1P5} plcg_mode_e;
  typedef enum logic {PLCG_CK_RUN, PLCG_CK_HOLD} plcg_ck_e;
endpackage
`default_nettype wire

// >>> verif/plcg_clock_gen_tb.sv
// Self-checking bench for the clock generator
`default_nettype none
module plcg_clock_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short lock time keeps the run brief
  localparam int LOCK = 20;
  localparam int FMIN = 192 * 24;
  localparam int FMAX = 192 * 28;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, awake_n = 1'b1;
  logic cv_valid = 1'b0, cv_lost = 1'b0, wdog = 1'b0, avs_waitrequest, rx_line;
  logic pll_enable, mcu_clk_run, usb_clk_run, dck, bck, fsy, tx_start, rx_valid, rx_b, rst_pulse, pd, pb, pf;
  logic [2:0]  avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd, d;
  logic [1:0]  skew = 2'h1;
  logic [1:0]  mode;
  logic [4:0]  pll_mult;
  logic [3:0]  pll_div;
  logic [16:0] seed = 17'h1670D;
  logic [16:0] line_seed = 17'h1670D;
  logic [63:0] exp_q[$];
  logic [7:0]  tbl[4] = '{8'hC3, 8'hD3, 8'hF3, 8'h03};
  plcg_pkg::plcg_mode_e want_m[4] = '{plcg_pkg::PLCG_M_PLL, plcg_pkg::PLCG_M_DIV2,
                                      plcg_pkg::PLCG_M_DIV1P5, plcg_pkg::PLCG_M_XTAL};
  int mismatches = 0;
  int samples_checked = 0;
  int k, n, i, hi, tot, bt, rv, tx_at, ones;

  plcg_clock_gen #(.LOCK_CYCLES(LOCK)) u_dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .rx_line, .subscriber_awake_n(awake_n),
    .cv_pair_valid(cv_valid), .cv_pair_lost(cv_lost), .watchdog_expired(wdog), .pll_enable,
    .pll_mult, .pll_div, .mcu_clk_mode(mode), .mcu_clk_run, .usb_clk_run, .interface_data_clock(dck),
    .interface_bit_clock(bck), .frame_sync(fsy), .tx_frame_start(tx_start), .rx_bit(rx_b),
    .rx_bit_valid(rx_valid), .line_reset_pulse(rst_pulse));
  plcg_line_model u_line (.clk, .reset_n, .skew, .rx_line);

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t %s seen %0h want %0h", $time, what, seen, want);
    end
  endtask
  task automatic bound(input int used, input int lim);
    if (used >= lim) begin
      mismatches++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop();
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (!avs_waitrequest) break;
    end
    bound(n, 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic expect_rd(input logic [2:0] a, input logic [31:0] want, input logic [31:0] mask);
    exp_q.push_back({mask, want});
    bus(1'b0, a, 32'h0);
  endtask

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    pd <= dck;
    pb <= bck;
    pf <= fsy;
    line_seed <= lfsr(line_seed);
    skew <= line_seed[1:0];
    if (avs_read && !avs_waitrequest && exp_q.size() > 0) begin
      check(avs_readdata & exp_q[0][63:32], exp_q[0][31:0], "read data");
      void'(exp_q.pop_front());
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check(32'({pll_enable, usb_clk_run, mode, pll_div, pll_mult}), 32'h78, "state after reset");
    expect_rd(3'h0, 32'h18, ALL);
    expect_rd(3'h1, 32'h3, ALL);
    expect_rd(3'h2, 32'h0, ALL);
    for (k = 3; k < 8; k++) begin
      if (k == 4) continue;
      bus(1'b1, 3'(k), ALL);
      expect_rd(3'(k), 32'h0, (k == 3) ? 32'h1 : ALL);
    end
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      d = (k == 0) ? ALL : {15'h7FFF, seed};
      bus(1'b1, 3'h0, d);
      bus(1'b1, 3'h1, d & 32'hFFFFFF0F);
      expect_rd(3'h0, d & 32'h1F, ALL);
      expect_rd(3'h1, d & 32'h0F, ALL);
      check(32'({pll_div, pll_mult}), 32'({d[3:0], d[4:0]}), "factor outputs");
    end
    $display("test registers done");
    bus(1'b1, 3'h0, 32'h18);
    bus(1'b1, 3'h1, 32'h03);
    repeat (3 * LOCK) @(posedge clk);
    expect_rd(3'h3, 32'h0, 32'h1);
    check(32'(pll_enable), 32'h0, "pll idle");
    bus(1'b1, 3'h1, 32'h43);
    for (i = 0; i < 20; i++) begin
      bus(1'b0, 3'h3, 32'h0);
      if (rd[0] === 1'b1) break;
    end
    bound(i, 20);
    check(32'(mode), 32'h0, "no switch before select");
    for (k = 0; k < 4; k++) begin
      bus(1'b1, 3'h1, 32'(tbl[k]));
      for (i = 0; i < 40 && (mode !== want_m[k] || mcu_clk_run !== 1'b1); i++) @(posedge clk);
      bound(i, 40);
      check(32'(mode), 32'(want_m[k]), "controller clock path");
      if (k == 1) begin
        bus(1'b1, 3'h2, 32'h1);
        for (i = 0; i < 40 && usb_clk_run !== 1'b1; i++) @(posedge clk);
        check(32'(usb_clk_run), 32'h1, "usb gate");
      end
    end
    $display("test clock path done");
    for (i = 0; i < 2 * FMAX && !(fsy && !pf); i++) @(posedge clk);
    bound(i, 2 * FMAX);
    {hi, tot, bt, rv, tx_at, ones} = '0;
    for (i = 0; i < 2 * FMAX; i++) begin
      @(posedge clk);
      if (bck !== pb) bt++;
      if (fsy && !pf) break;
      if (dck && !pd) tot++;
      if (dck && !pd && fsy) hi++;
      if (rx_valid) rv++;
      if (rx_valid && rx_b) ones++;
      if (tx_start) tx_at = tot;
    end
    bound(i, 2 * FMAX);
    check(32'(tot), 32'hC0, "data clocks per frame");
    check(32'(hi), 32'h40, "frame sync high");
    check(32'(bt), 32'hC0, "bit clock toggles");
    check(32'(rv), 32'h18, "bit decisions");
    check(32'(ones >= 10 && ones <= 14), 32'h1, "majority bits");
    check(32'(tx_at >= 15 && tx_at <= 17), 32'h1, "transmit offset");
    check(32'(i >= FMIN && i <= FMAX), 32'h1, "frame length");
    // Start in the low phase so only a snap can raise frame sync
    for (i = 0; i < FMAX && fsy === 1'b1; i++) @(posedge clk);
    bound(i, FMAX);
    cv_lost <= 1'b1;
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      cv_lost <= 1'b0;
      cv_valid <= (k < 3);
      @(posedge clk);
      cv_valid <= 1'b0;
      repeat (2) @(posedge clk);
    end
    check(32'(fsy), 32'h1, "frame snapped");
    expect_rd(3'h3, 32'h2, 32'h2);
    $display("test line clocks done");
    for (k = 0; k < 4; k++) begin
      case (k)
        0: bus(1'b1, 3'h4, 32'h10);
        1: bus(1'b1, 3'h4, 32'h05);
        2: wdog <= 1'b1;
        default: awake_n <= 1'b0;
      endcase
      @(posedge clk);
      wdog <= 1'b0;
      repeat (4) @(posedge clk);
      awake_n <= 1'b1;
      for (i = 0; i < 20 && rst_pulse !== 1'b1; i++) @(posedge clk);
      bound(i, 20);
      expect_rd(3'h3, 32'h8, 32'h8);
      for (i = 0; i < 3 * FMAX && rst_pulse === 1'b1; i++) @(posedge clk);
      bound(i, 3 * FMAX);
      check(32'(i >= FMIN && i <= 2 * FMAX), 32'h1, "reset pulse length");
    end
    expect_rd(3'h4, 32'h5, ALL);
    $display("test reset pulses done");
    report_and_stop();
  end
  initial begin
    #2_400_000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> verif/plcg_line_model.sv
// Receive line model: bit stream with jittered bit lengths
`default_nettype none
module plcg_line_model #(
  parameter int BIT_CLKS = 208
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Jitter control
  input wire logic [1:0] skew,
  // Line pin
  output logic           rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt;
  logic [7:0] pat;
  // Bit length moves by -2..+1 clocks so the tracker must keep correcting
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      pat <= 8'hB4;
      rx_line <= 1'b1;
    end else if (cnt >= BIT_CLKS - 3 + int'(skew)) begin
      cnt <= 0;
      pat <= {pat[6:0], pat[7]};
      rx_line <= pat[7];
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/plcg_monitor.sv
// Port checker for the clock generator, bound to every instance
`default_nettype none
module plcg_monitor (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Bus and trigger inputs
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       watchdog_expired,
  // Clock path outputs
  input wire logic       pll_enable,
  input wire logic [4:0] pll_mult,
  input wire logic [3:0] pll_div,
  input wire logic [1:0] mcu_clk_mode,
  input wire logic       mcu_clk_run,
  input wire logic       usb_clk_run,
  // Line outputs
  input wire logic       interface_data_clock,
  input wire logic       interface_bit_clock,
  input wire logic       frame_sync,
  input wire logic       tx_frame_start,
  input wire logic       line_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_dck_up; $rose(interface_data_clock); endsequence
  // Two runs of eight leave room for the switch gap
  sequence s_off_long; !pll_enable [*8] ##1 !pll_enable [*8]; endsequence
  property p_reset_state; $rose(reset_n) |-> pll_mult == 5'h18 && pll_div == 4'h3 && !usb_clk_run; endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  property p_xtal_off; s_off_long |-> mcu_clk_mode == 2'h0; endproperty
  a_xtal_off: assert property (p_xtal_off) else $error("pll path without enable");
  property p_gap; $changed(mcu_clk_mode) |-> !$past(mcu_clk_run) && !$past(usb_clk_run); endproperty
  a_gap: assert property (p_gap) else $error("source switched with gates open");
  property p_wait_one; s_req |=> !avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");
  property p_bck; s_dck_up |-> ##[0:2] $changed(interface_bit_clock); endproperty
  a_bck: assert property (p_bck) else $error("bit clock not following data clock");
  property p_dck_min; s_dck_up |-> interface_data_clock [*5]; endproperty
  a_dck_min: assert property (p_dck_min) else $error("data clock high too short");
  property p_tx; tx_frame_start |-> frame_sync && !$past(tx_frame_start); endproperty
  a_tx: assert property (p_tx) else $error("transmit frame start misplaced");
  property p_trig; watchdog_expired |=> line_reset_pulse; endproperty
  a_trig: assert property (p_trig) else $error("reset pulse not started");
  property p_hold; $rose(line_reset_pulse) |-> line_reset_pulse [*8]; endproperty
  a_hold: assert property (p_hold) else $error("reset pulse too short");
endmodule
bind plcg_clock_gen plcg_monitor u_mon (.clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest,
  .watchdog_expired, .pll_enable, .pll_mult, .pll_div, .mcu_clk_mode, .mcu_clk_run, .usb_clk_run,
  .interface_data_clock, .interface_bit_clock, .frame_sync, .tx_frame_start, .line_reset_pulse);
`default_nettype wire
